// File: design/crp_pkg.sv
// constants and types for the code read-out protection block
package crp_pkg;
  // =====================================================
  // geometry
  localparam int unsigned CODE_AW = 12;
  localparam int unsigned KEY_DEPTH = 32;
  localparam int unsigned KEY_AW = 5;
  localparam int unsigned DATA_W = 8;
  // =====================================================
  // reset values
  localparam logic [KEY_AW-1:0] KEY_IDX_RST = 5'h00;
  localparam logic [1:0] SEC_BITS_RST = 2'h3;
  localparam logic [DATA_W-1:0] KEY_ERASED = 8'hff;
  localparam logic [DATA_W-1:0] REFUSED_DATA = 8'hff;
  // =====================================================
  // access modes from the programmer
  typedef enum logic [1:0] {
    CRP_MODE_CODE = 2'b00,
    CRP_MODE_KEY = 2'b01,
    CRP_MODE_SEC = 2'b10,
    CRP_MODE_NONE = 2'b11
  } crp_mode_t;
endpackage : crp_pkg

// File: design/crp_key_mem.sv
// key byte store, registered read, no external read path
`timescale 1ns/1ps
module crp_key_mem
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [crp_pkg::KEY_AW-1:0] wr_addr,
  input wire logic [crp_pkg::DATA_W-1:0] wr_data,
  input wire logic [crp_pkg::KEY_AW-1:0] rd_addr,
  output logic [crp_pkg::DATA_W-1:0] rd_data
);
  logic [crp_pkg::DATA_W-1:0] mem [crp_pkg::KEY_DEPTH];

  // =====================================================
  // storage; erased state is all ones, meaning no scrambling
  initial
  begin
    for (int i = 0; i < crp_pkg::KEY_DEPTH; i++)
    begin
      mem[i] = crp_pkg::KEY_ERASED;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule : crp_key_mem

// File: design/crp_top.sv
// code read-out protection: key scrambling and security bit gating
// Operation
// - code bytes leave XNORed with a key byte
// - key byte advances with each read that is not refused
// - stored key bytes are never readable
// - verify returns only key-combined data
// - two independent security bits restrict access
// - bit one blocks external table reads, programming
// - bit two still programmable after bit one
// - bit one alone still allows verify
// - bit two refuses all verify read-out
// - all-ones key leaves data unchanged
// - security bits stored active low
`timescale 1ns/1ps
module crp_top
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] prog_mode,
  input wire logic prog_req,
  input wire logic [crp_pkg::CODE_AW-1:0] prog_addr,
  input wire logic [crp_pkg::DATA_W-1:0] prog_data,
  input wire logic verify_req,
  input wire logic table_read_req,
  input wire logic table_read_external,
  input wire logic [crp_pkg::DATA_W-1:0] code_rd_data,
  output logic code_wr_en,
  output logic [crp_pkg::CODE_AW-1:0] code_wr_addr,
  output logic [crp_pkg::DATA_W-1:0] code_wr_data,
  output logic [crp_pkg::DATA_W-1:0] out_data,
  output logic out_valid,
  output logic out_refused,
  output logic [1:0] sec_bits_n
);
  // =====================================================
  // security state
  logic [1:0] sec_n;
  logic lock_prog;
  logic lock_verify;
  logic key_wr;
  logic sec_wr;
  logic [crp_pkg::KEY_AW-1:0] key_idx;
  logic [crp_pkg::DATA_W-1:0] key_byte;
  logic rd_go;
  logic rd_stage;
  logic rd_refuse;

  // =====================================================
  // mode decode, shared by every write path and its checks
  function automatic logic mode_is(input logic [1:0] mode, input crp_pkg::crp_mode_t want);
    return mode == 2'(want);
  endfunction : mode_is

  assign lock_prog = ~sec_n[0];
  assign lock_verify = ~sec_n[1];
  assign key_wr = prog_req && mode_is(prog_mode, crp_pkg::CRP_MODE_KEY) && !lock_prog;
  assign sec_wr = prog_req && mode_is(prog_mode, crp_pkg::CRP_MODE_SEC);

  // programming a bit only clears it; bit one never blocks bit two
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_n <= crp_pkg::SEC_BITS_RST;
    end
    else if (sec_wr)
    begin
      sec_n <= sec_n & prog_data[1:0];
    end
  end

  // =====================================================
  // code memory programming path
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_wr_en <= 1'b0;
      code_wr_addr <= '0;
      code_wr_data <= '0;
    end
    else
    begin
      code_wr_en <= prog_req && mode_is(prog_mode, crp_pkg::CRP_MODE_CODE) && !lock_prog;
      code_wr_addr <= prog_addr;
      code_wr_data <= prog_data;
    end
  end

  // =====================================================
  // key store; its read port feeds only the scrambler
  crp_key_mem u_key
  (
    .ref_clk(ref_clk),
    .wr_en(key_wr),
    .wr_addr(prog_addr[crp_pkg::KEY_AW-1:0]),
    .wr_data(prog_data),
    .rd_addr(key_idx),
    .rd_data(key_byte)
  );

  // =====================================================
  // read sequencing: table reads from external code are blocked while bit one is set
  assign rd_go = verify_req || (table_read_req && !(table_read_external && lock_prog));

  // index wraps naturally at 32 because it is five bits wide
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_idx <= crp_pkg::KEY_IDX_RST;
    end
    else if (rd_go && !(verify_req && lock_verify))
    begin
      key_idx <= key_idx + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_stage <= 1'b0;
      rd_refuse <= 1'b0;
    end
    else
    begin
      rd_stage <= rd_go && !(verify_req && lock_verify);
      rd_refuse <= (verify_req && lock_verify) || (table_read_req && !rd_go);
    end
  end

  // =====================================================
  // output stage: only scrambled data ever leaves
  // array byte and key byte both arrive one edge after the request;
  // an extra register on the array byte would pair it with the next key byte
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_data <= crp_pkg::REFUSED_DATA;
      out_valid <= 1'b0;
      out_refused <= 1'b0;
    end
    else
    begin
      out_valid <= rd_stage;
      out_refused <= rd_refuse;
      out_data <= rd_stage ? ~(code_rd_data ^ key_byte) : crp_pkg::REFUSED_DATA;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_bits_n <= crp_pkg::SEC_BITS_RST;
    end
    else
    begin
      sec_bits_n <= sec_n;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // =====================================================
  // write path checks
  prog_blocked_a: assert property (
    lock_prog |=> !code_wr_en)
    else $error("code written while locked");
  key_blocked_a: assert property (
    lock_prog |-> !key_wr)
    else $error("key written while locked");
  code_wr_src_a: assert property (
    code_wr_en |-> $past(prog_req) && mode_is($past(prog_mode), crp_pkg::CRP_MODE_CODE))
    else $error("code written without a code request");
  bit_sticky_a: assert property (
    lock_prog |=> lock_prog)
    else $error("security bit reverted");
  bit_two_open_a: assert property (
    sec_wr && !prog_data[1] |=> lock_verify)
    else $error("bit two not programmable");
  bits_mirror_a: assert property (
    1'b1 |=> sec_bits_n == $past(sec_n))
    else $error("security state not shown");

  // =====================================================
  // read path checks
  verify_refused_a: assert property (
    verify_req && lock_verify |-> ##2 out_refused && !out_valid)
    else $error("verify not refused under bit two");
  verify_allowed_a: assert property (
    verify_req && !lock_verify |-> ##2 out_valid)
    else $error("verify lost with bit one only");
  table_ok_a: assert property (
    table_read_req && !table_read_external && !verify_req |-> ##2 out_valid)
    else $error("internal table read lost");
  ext_table_a: assert property (
    table_read_req && table_read_external && lock_prog && !verify_req |-> ##2 out_refused)
    else $error("external table read not blocked");
  out_excl_a: assert property (
    !(out_valid && out_refused))
    else $error("read both answered and refused");
  refused_ff_a: assert property (
    !out_valid |-> out_data == crp_pkg::REFUSED_DATA)
    else $error("data shown without a valid read");
  key_adv_a: assert property (
    rd_stage |-> key_idx == $past(key_idx) + 5'h01)
    else $error("key index did not advance");
  refuse_hold_a: assert property (
    verify_req && lock_verify |=> key_idx == $past(key_idx))
    else $error("refused read moved the key index");
  key_wrap_a: assert property (
    rd_stage && $past(key_idx) == 5'(crp_pkg::KEY_DEPTH - 1) |-> key_idx == crp_pkg::KEY_IDX_RST)
    else $error("key index did not wrap");
  xnor_out_a: assert property (
    rd_stage |=> out_data == ~($past(code_rd_data) ^ $past(key_byte)))
    else $error("output not key combined");

  verify_c: cover property (verify_req ##2 out_valid);
  table_c: cover property (table_read_req && table_read_external ##2 out_refused);
  refuse_c: cover property (verify_req && lock_verify ##2 out_refused);
  lock_c: cover property (sec_wr ##1 lock_prog);
  wrap_c: cover property (rd_go && key_idx == 5'h1f);
endmodule : crp_top

// File: dv/crp_code_array.sv
// code array model behind the protection block
`timescale 1ns/1ps
module crp_code_array
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [crp_pkg::CODE_AW-1:0] wr_addr,
  input wire logic [crp_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic [crp_pkg::CODE_AW-1:0] rd_addr,
  output logic [crp_pkg::DATA_W-1:0] rd_data
);
  logic [crp_pkg::DATA_W-1:0] mem [0:(1<<crp_pkg::CODE_AW)-1];
  initial rd_data = 8'h00;
  // valid one cycle only; inverted on each idle edge after, so a stale byte matches again every second cycle
  always @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= rd_req ? mem[rd_addr] : ~rd_data;
  end
endmodule : crp_code_array

// File: dv/tb_crp_top.sv
// self-checking bench for the read-out protection block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_crp_top;
  logic ref_clk, rst_n, prog_req, verify_req, table_read_req, table_read_external;
  logic [1:0] prog_mode;
  logic [1:0] sec_bits_n;
  logic [11:0] prog_addr, rd_addr, code_wr_addr;
  logic [7:0] prog_data, code_rd_data, code_wr_data, out_data;
  logic code_wr_en, out_valid, out_refused;
  int err_total = 0;
  int checked = 0;
  crp_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .prog_mode(prog_mode), .prog_req(prog_req),
    .prog_addr(prog_addr), .prog_data(prog_data), .verify_req(verify_req),
    .table_read_req(table_read_req), .table_read_external(table_read_external),
    .code_rd_data(code_rd_data), .code_wr_en(code_wr_en), .code_wr_addr(code_wr_addr),
    .code_wr_data(code_wr_data), .out_data(out_data), .out_valid(out_valid),
    .out_refused(out_refused), .sec_bits_n(sec_bits_n));
  crp_code_array arr (.ref_clk(ref_clk), .wr_en(code_wr_en), .wr_addr(code_wr_addr),
    .wr_data(code_wr_data), .rd_req(verify_req | table_read_req), .rd_addr(rd_addr),
    .rd_data(code_rd_data));
  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================
  // helpers
  function automatic logic [7:0] key_of(int i);
    return 8'ha5 ^ 8'(i % 32);
  endfunction : key_of
  function automatic logic [7:0] code_of(int a);
    return 8'h3c ^ 8'(a * 7);
  endfunction : code_of
  task automatic prog(logic [1:0] m, logic [11:0] a, logic [7:0] d, logic wr);
    @(negedge ref_clk);
    {prog_mode, prog_addr, prog_data, prog_req} = {m, a, d, 1'b1};
    @(negedge ref_clk);
    prog_req = 0;
    `CHK("code_wr_en", wr, code_wr_en)
    if (wr)
      `CHK("code_wr", {a, d}, {code_wr_addr, code_wr_data})
  endtask : prog
  task automatic rd(logic tbl, logic ext, logic [11:0] a, logic ok, logic [7:0] e);
    @(negedge ref_clk);
    {verify_req, table_read_req, table_read_external, rd_addr} = {!tbl, tbl, ext, a};
    @(negedge ref_clk);
    {verify_req, table_read_req} = 2'h0;
    @(negedge ref_clk);
    `CHK("out_valid", ok, out_valid)
    `CHK("out_refused", !ok, out_refused)
    `CHK("out_data", ok ? e : 8'hff, out_data)
  endtask : rd
  // ==========================================
  // scenarios
  task automatic s_reset();
    rst_n = 0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1;
    `CHK("sec_bits_n", 2'h3, sec_bits_n)
  endtask : s_reset
  task automatic s_plain();
    for (int a = 0; a < 4; a++)
      prog(crp_pkg::CRP_MODE_CODE, 12'(a), code_of(a), 1);
    rd(0, 0, 12'h000, 1, code_of(0));
    rd(1, 1, 12'h001, 1, code_of(1));
  endtask : s_plain
  task automatic s_key();
    s_reset();
    for (int i = 0; i < 32; i++)
      prog(crp_pkg::CRP_MODE_KEY, 12'(i), key_of(i), 0);
    // 33 reads prove the wrap back to the first key byte
    for (int n = 0; n < 33; n++)
      rd(n[0], 0, 12'(n % 4), 1, ~(code_of(n % 4) ^ key_of(n)));
  endtask : s_key
  task automatic s_bits();
    prog(crp_pkg::CRP_MODE_SEC, 12'h000, 8'hfe, 0);
    // the mirrored state lags the stored bits by one edge
    @(negedge ref_clk);
    `CHK("sec_bits_n", 2'h2, sec_bits_n)
    prog(crp_pkg::CRP_MODE_CODE, 12'h005, 8'h11, 0);
    prog(crp_pkg::CRP_MODE_KEY, 12'h001, 8'h00, 0);
    rd(1, 1, 12'h000, 0, 8'h00);
    rd(0, 0, 12'h001, 1, ~(code_of(1) ^ key_of(1)));
    prog(crp_pkg::CRP_MODE_SEC, 12'h000, 8'hfd, 0);
    @(negedge ref_clk);
    `CHK("sec_bits_n", 2'h0, sec_bits_n)
    rd(0, 0, 12'h002, 0, 8'h00);
  endtask : s_bits
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial
  begin
    {prog_req, verify_req, table_read_req, table_read_external} = 4'h0;
    {prog_mode, prog_addr, prog_data, rd_addr} = '1;
    s_reset();
    s_plain();
    s_key();
    s_bits();
    test_done();
  end
  // hang guard
  initial
  begin
    #1ms;
    err_total++;
    test_done();
  end
endmodule : tb_crp_top
